/* File: rtl/gate_drv_pkg.sv */
// constants shared by the gate driver control slice
package gate_drv_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 8;

  // register bus
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_DELAY  = 8'h04;
  localparam logic [7:0]  OFS_MASK   = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0C;

  // control register fields
  localparam int CTRL_DRV_EN_BIT = 0;
  localparam logic CTRL_DRV_EN_RST = 1'b0;

  // delay register: two bits per channel, channel n at bits 2n+1:2n
  localparam int NUM_CH      = 6;
  localparam int NUM_LS      = 3;
  localparam int DLY_SEL_W   = 2;
  localparam logic [11:0] DELAY_RST = 12'h000;

  // mask register fields
  localparam int MASK_LS_BIT = 0;
  localparam int MASK_HS_BIT = 1;
  localparam logic [1:0] MASK_RST = 2'b00;

  // status register fields
  localparam int STAT_DRV_LSB    = 0;
  localparam int STAT_LS_TRIP    = 8;
  localparam int STAT_HS_TRIP    = 9;
  localparam int STAT_EVT_LEVEL  = 10;

  // propagation delays in ns, index = delay setting code
  localparam int LS_RISE_NS [4] = '{130, 170, 230, 360};
  localparam int LS_FALL_NS [4] = '{140, 180, 250, 380};
  localparam int HS_RISE_NS [4] = '{160, 200, 260, 380};
  localparam int HS_FALL_NS [4] = '{140, 180, 240, 370};

  localparam int CNT_W = 6;

  // least time: round up to whole cycles
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  localparam logic [4*CNT_W-1:0] LS_RISE_TBL = {ns_to_cyc(LS_RISE_NS[3]), ns_to_cyc(LS_RISE_NS[2]),
                                                ns_to_cyc(LS_RISE_NS[1]), ns_to_cyc(LS_RISE_NS[0])};
  localparam logic [4*CNT_W-1:0] LS_FALL_TBL = {ns_to_cyc(LS_FALL_NS[3]), ns_to_cyc(LS_FALL_NS[2]),
                                                ns_to_cyc(LS_FALL_NS[1]), ns_to_cyc(LS_FALL_NS[0])};
  localparam logic [4*CNT_W-1:0] HS_RISE_TBL = {ns_to_cyc(HS_RISE_NS[3]), ns_to_cyc(HS_RISE_NS[2]),
                                                ns_to_cyc(HS_RISE_NS[1]), ns_to_cyc(HS_RISE_NS[0])};
  localparam logic [4*CNT_W-1:0] HS_FALL_TBL = {ns_to_cyc(HS_FALL_NS[3]), ns_to_cyc(HS_FALL_NS[2]),
                                                ns_to_cyc(HS_FALL_NS[1]), ns_to_cyc(HS_FALL_NS[0])};

endpackage

/* File: rtl/drive_delay_chan.sv */
// one driver channel: selectable rise/fall propagation delay and forced switch-off
`timescale 1ns/1ps
module drive_delay_chan
  import gate_drv_pkg::*;
#(
  parameter logic [4*CNT_W-1:0] RISE_TBL = LS_RISE_TBL,
  parameter logic [4*CNT_W-1:0] FALL_TBL = LS_FALL_TBL
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rstn_i,
  // control
  input  wire logic                 enable_i,
  input  wire logic                 ctrl_i,
  input  wire logic [DLY_SEL_W-1:0] sel_i,
  // output
  output logic                      drive_o
);

  logic [CNT_W-1:0] cnt_q;
  logic             drv_q;
  logic [CNT_W-1:0] target;

  // table lookup by delay code, rising or falling edge
  always_comb begin
    if (ctrl_i) begin
      target = RISE_TBL[sel_i*CNT_W +: CNT_W];
    end else begin
      target = FALL_TBL[sel_i*CNT_W +: CNT_W];
    end
  end

  // a pulse shorter than the delay is swallowed, as an analog delay line would
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !enable_i) begin
      cnt_q <= '0;
      drv_q <= 1'b0;
    end else if (ctrl_i == drv_q) begin
      cnt_q <= '0;
    end else if (cnt_q + 1'b1 >= target) begin
      cnt_q <= '0;
      drv_q <= ctrl_i;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign drive_o = drv_q;

endmodule

/* File: rtl/gate_driver_control_protect.sv */
// gate driver control slice: enable, per-channel delay and group protection
//
// How it works
// - after reset every driver channel stays off until software enables.
// - when enabled each output follows its own control input.
// - each channel has a two-bit code picking one of four delays.
// - low-side codes give 130/140, 170/180, 230/250, 360/380 ns.
// - high-side codes give 160/140, 200/180, 260/240, 380/370 ns.
// - channels 0 to 2 form low group, 3 to 5 high group.
// - protection event disables low, high or both groups per mask bits.
`timescale 1ns/1ps
module gate_driver_control_protect
  import gate_drv_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // control inputs from ports or pwm
  input  wire logic [NUM_LS-1:0] low_side_ctrl_i,
  input  wire logic [NUM_LS-1:0] high_side_ctrl_i,
  // protection from analog front end
  input  wire logic              protect_event_one_i,
  // gate driver outputs
  output logic      [NUM_LS-1:0] low_side_drive_out_o,
  output logic      [NUM_LS-1:0] high_side_drive_out_o
);

  // registers
  logic                        drv_en_q;
  logic [NUM_CH*DLY_SEL_W-1:0] delay_q;
  logic [1:0]                  mask_q;
  logic                        ls_trip_q;
  logic                        hs_trip_q;
  logic [DATA_W-1:0]           rdata_q;

  // synchronisers
  logic [NUM_CH-1:0] ctrl_meta_q;
  logic [NUM_CH-1:0] ctrl_sync_q;
  logic              evt_meta_q;
  logic              evt_sync_q;

  logic [NUM_CH-1:0] ch_en;
  logic [NUM_CH-1:0] drive;
  logic              ls_off;
  logic              hs_off;

  logic wr_ctrl;
  logic wr_delay;
  logic wr_mask;
  logic wr_status;
  logic ls_clr;
  logic hs_clr;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  assign wr_ctrl   = wr_i && hit(addr_i, OFS_CTRL);
  assign wr_delay  = wr_i && hit(addr_i, OFS_DELAY);
  assign wr_mask   = wr_i && hit(addr_i, OFS_MASK);
  assign wr_status = wr_i && hit(addr_i, OFS_STATUS);

  // write one to a trip bit clears it; the other status bits ignore writes
  assign ls_clr = wr_status && wdata_i[STAT_LS_TRIP];
  assign hs_clr = wr_status && wdata_i[STAT_HS_TRIP];

  // a group is held off by its sticky trip, or by the live masked event before the trip lands
  function automatic logic group_off(input logic trip, input logic evt, input logic msk);
    return trip || (evt && msk);
  endfunction

  // pins are asynchronous to ref_clk_i, so two flops before any use
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl_meta_q <= '0;
      ctrl_sync_q <= '0;
    end else begin
      ctrl_meta_q <= {high_side_ctrl_i, low_side_ctrl_i};
      ctrl_sync_q <= ctrl_meta_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      evt_meta_q <= 1'b0;
      evt_sync_q <= 1'b0;
    end else begin
      evt_meta_q <= protect_event_one_i;
      evt_sync_q <= evt_meta_q;
    end
  end

  // global enable, cleared by reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      drv_en_q <= CTRL_DRV_EN_RST;
    end else if (wr_ctrl) begin
      drv_en_q <= wdata_i[CTRL_DRV_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      delay_q <= DELAY_RST;
    end else if (wr_delay) begin
      delay_q <= wdata_i[NUM_CH*DLY_SEL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mask_q <= MASK_RST;
    end else if (wr_mask) begin
      mask_q <= {wdata_i[MASK_HS_BIT], wdata_i[MASK_LS_BIT]};
    end
  end

  // trips are sticky: a short event still shuts the group until software clears it;
  // an event present while the clear is written keeps the trip set
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ls_trip_q <= 1'b0;
    end else if (evt_sync_q && mask_q[MASK_LS_BIT]) begin
      ls_trip_q <= 1'b1;
    end else if (ls_clr) begin
      ls_trip_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hs_trip_q <= 1'b0;
    end else if (evt_sync_q && mask_q[MASK_HS_BIT]) begin
      hs_trip_q <= 1'b1;
    end else if (hs_clr) begin
      hs_trip_q <= 1'b0;
    end
  end

  // the live event also blocks its group, so no extra cycle passes before shutdown
  assign ls_off = group_off(ls_trip_q, evt_sync_q, mask_q[MASK_LS_BIT]);
  assign hs_off = group_off(hs_trip_q, evt_sync_q, mask_q[MASK_HS_BIT]);

  // pin to output: two sync flops, then the selected count of whole cycles; counts round up,
  // so no output moves before its set delay, and a pulse shorter than the delay is lost
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      if (g < NUM_LS) begin : g_ls
        assign ch_en[g] = drv_en_q && !ls_off;
        drive_delay_chan #(
          .RISE_TBL (LS_RISE_TBL),
          .FALL_TBL (LS_FALL_TBL)
        ) u_chan (
          .ref_clk_i (ref_clk_i),
          .rstn_i    (rstn_i),
          .enable_i  (ch_en[g]),
          .ctrl_i    (ctrl_sync_q[g]),
          .sel_i     (delay_q[g*DLY_SEL_W +: DLY_SEL_W]),
          .drive_o   (drive[g])
        );
      end else begin : g_hs
        assign ch_en[g] = drv_en_q && !hs_off;
        drive_delay_chan #(
          .RISE_TBL (HS_RISE_TBL),
          .FALL_TBL (HS_FALL_TBL)
        ) u_chan (
          .ref_clk_i (ref_clk_i),
          .rstn_i    (rstn_i),
          .enable_i  (ch_en[g]),
          .ctrl_i    (ctrl_sync_q[g]),
          .sel_i     (delay_q[g*DLY_SEL_W +: DLY_SEL_W]),
          .drive_o   (drive[g])
        );
      end
    end
  endgenerate

  assign low_side_drive_out_o  = drive[NUM_LS-1:0];
  assign high_side_drive_out_o = drive[NUM_CH-1:NUM_LS];

  // read data valid in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      rdata_q <= '0;
      case (addr_i)
        OFS_CTRL: begin
          rdata_q[CTRL_DRV_EN_BIT] <= drv_en_q;
        end
        OFS_DELAY: begin
          rdata_q[NUM_CH*DLY_SEL_W-1:0] <= delay_q;
        end
        OFS_MASK: begin
          rdata_q[MASK_LS_BIT] <= mask_q[0];
          rdata_q[MASK_HS_BIT] <= mask_q[1];
        end
        OFS_STATUS: begin
          // live outputs and the synchronised event level, not the raw pin
          rdata_q[STAT_DRV_LSB +: NUM_CH] <= drive;
          rdata_q[STAT_LS_TRIP]           <= ls_trip_q;
          rdata_q[STAT_HS_TRIP]           <= hs_trip_q;
          rdata_q[STAT_EVT_LEVEL]         <= evt_sync_q;
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

endmodule

/* File: dv/gate_drv_asserts.sv */
// port assertions for the gate driver control slice
`timescale 1ns/1ps
module gate_drv_asserts
  import gate_drv_pkg::*;
(
  // watched ports
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_LS-1:0] low_side_ctrl_i,
  input wire logic [NUM_LS-1:0] high_side_ctrl_i,
  input wire logic              protect_event_one_i,
  input wire logic [NUM_LS-1:0] low_side_drive_out_o,
  input wire logic [NUM_LS-1:0] high_side_drive_out_o
);
  logic       en_q;
  logic [1:0] msk_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow of enable and masks, seen only through bus writes
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      en_q  <= 1'b0;
      msk_q <= 2'b00;
    end else if (wr_i && addr_i == OFS_CTRL) begin
      en_q <= wdata_i[CTRL_DRV_EN_BIT];
    end else if (wr_i && addr_i == OFS_MASK) begin
      msk_q <= wdata_i[1:0];
    end
  end
  AST_RESET_OFF: assert property ($rose(rstn_i) |-> {low_side_drive_out_o, high_side_drive_out_o} == 6'h00)
    else $error("driver on right after reset");
  AST_DISABLED_OFF: assert property (!en_q |=> {low_side_drive_out_o, high_side_drive_out_o} == 6'h00)
    else $error("driver on while disabled");
  AST_RISE_NEEDS_EN: assert property (($rose(low_side_drive_out_o[0]) || $rose(high_side_drive_out_o[0]))
    |-> $past(en_q))
    else $error("driver rose without enable");
  // shortest code is the floor: 17 low and 20 high cycles after the sync stages
  AST_LS_RISE: assert property ($rose(low_side_drive_out_o[0])
    |-> $past(low_side_ctrl_i[0], 3) && $past(low_side_ctrl_i[0], 18))
    else $error("low side rose too early");
  AST_HS_RISE: assert property ($rose(high_side_drive_out_o[0])
    |-> $past(high_side_ctrl_i[0], 3) && $past(high_side_ctrl_i[0], 21))
    else $error("high side rose too early");
  AST_LS_TRIP: assert property (protect_event_one_i [*4] ##0 msk_q[MASK_LS_BIT]
    |=> low_side_drive_out_o == 3'h0)
    else $error("low group not shut down");
  AST_HS_TRIP: assert property (protect_event_one_i [*4] ##0 msk_q[MASK_HS_BIT]
    |=> high_side_drive_out_o == 3'h0)
    else $error("high group not shut down");
  AST_READ_EN: assert property (rd_i && addr_i == OFS_CTRL |=> rdata_o == {{(DATA_W-1){1'b0}}, en_q})
    else $error("enable bit read back wrong");
endmodule
bind gate_driver_control_protect gate_drv_asserts u_asserts (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .low_side_ctrl_i, .high_side_ctrl_i, .protect_event_one_i, .low_side_drive_out_o, .high_side_drive_out_o);

/* File: dv/half_bridge_model.sv */
// three half-bridge legs switched by the gate drives
`timescale 1ns/1ps
module half_bridge_model (
  // gate drives
  input  wire logic [2:0] low_on_i,
  input  wire logic [2:0] high_on_i,
  // phase node high and shoot-through per leg
  output logic      [2:0] phase_o,
  output logic      [2:0] shoot_o
);
  // a leg with both switches off is read as low; no dead-time check here
  assign phase_o = high_on_i & ~low_on_i;
  assign shoot_o = high_on_i & low_on_i;
endmodule

/* File: dv/gate_driver_control_protect_test.sv */
// self-checking bench for the gate driver control slice
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module gate_driver_control_protect_test
  import gate_drv_pkg::*;
;
  logic              ref_clk_i;
  logic              rstn_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic [NUM_LS-1:0] ls_ctrl;
  logic [NUM_LS-1:0] hs_ctrl;
  logic              evt;
  logic [NUM_LS-1:0] ls_out;
  logic [NUM_LS-1:0] hs_out;
  logic [2:0]        phase;
  logic [2:0]        shoot;
  int                failures;
  int                checked;
  int                cycles;
  gate_driver_control_protect u_dut (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .low_side_ctrl_i(ls_ctrl), .high_side_ctrl_i(hs_ctrl), .protect_event_one_i(evt),
    .low_side_drive_out_o(ls_out), .high_side_drive_out_o(hs_out));
  half_bridge_model u_bridge (.low_on_i(ls_out), .high_on_i(hs_out), .phase_o(phase), .shoot_o(shoot));
  initial begin
    ref_clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
  end
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ceiling well above the roughly 1200 cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask
  task automatic drv(input logic [2:0] l, input logic [2:0] h);
    @(posedge ref_clk_i);
    ls_ctrl <= l;
    hs_ctrl <= h;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // two sync stages plus the rounded-up delay, and up to two edges more
  task automatic meas(input bit hs, input logic lv, input int ns);
    int n;
    int e;
    e = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    n = 0;
    if (hs) drv(3'h0, {3{lv}});
    else drv({3{lv}}, 3'h0);
    do begin
      @(negedge ref_clk_i);
      n++;
    end while ((hs ? hs_out[0] : ls_out[0]) !== lv && n < 80);
    `CHK("delay", 1'b1, n >= e + 2 && n <= e + 4)
    wait_n(3);
    `CHK("group", {3{lv}}, hs ? hs_out : ls_out)
  endtask
  task automatic t_idle();
    logic [31:0] d;
    `CHK("out", 6'h00, {hs_out, ls_out})
    wr(8'h10, 32'hFFFF_FFFF);
    rd(OFS_CTRL, d);
    `CHK("ctrl", 32'h0000_0000, d)
    rd(OFS_DELAY, d);
    `CHK("delay reg", 32'h0000_0000, d)
    rd(OFS_MASK, d);
    `CHK("mask", 32'h0000_0000, d)
    rd(8'h10, d);
    `CHK("unmapped", 32'h0000_0000, d)
    drv(3'h7, 3'h7);
    wait_n(60);
    `CHK("out", 6'h00, {hs_out, ls_out})
    wr(OFS_CTRL, 32'h0000_0001);
    wait_n(60);
    `CHK("out", 6'h3F, {hs_out, ls_out})
    wr(OFS_CTRL, 32'h0000_0000);
    wait_n(3);
    `CHK("out", 6'h00, {hs_out, ls_out})
    wr(OFS_CTRL, 32'h0000_0001);
    drv(3'h0, 3'h0);
    wait_n(60);
    $display("test idle done");
  endtask
  task automatic t_delay();
    logic [31:0] d;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_DELAY, {20'h0_0000, {6{c[1:0]}}});
      rd(OFS_DELAY, d);
      `CHK("delay reg", {6{c[1:0]}}, d[11:0])
      meas(1'b0, 1'b1, LS_RISE_NS[c]);
      meas(1'b0, 1'b0, LS_FALL_NS[c]);
      meas(1'b1, 1'b1, HS_RISE_NS[c]);
      `CHK("phase", 3'h7, phase)
      `CHK("shoot", 3'h0, shoot)
      meas(1'b1, 1'b0, HS_FALL_NS[c]);
    end
    $display("test delay done");
  endtask
  task automatic t_protect();
    logic [31:0] d;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MASK, 32'(m));
      rd(OFS_MASK, d);
      `CHK("mask", m[1:0], d[1:0])
      drv(3'h7, 3'h7);
      wait_n(60);
      @(posedge ref_clk_i);
      evt <= 1'b1;
      wait_n(6);
      `CHK("low", m[0] ? 3'h0 : 3'h7, ls_out)
      `CHK("high", m[1] ? 3'h0 : 3'h7, hs_out)
      rd(OFS_STATUS, d);
      `CHK("event", 1'b1, d[STAT_EVT_LEVEL])
      `CHK("status low", m[0] ? 3'h0 : 3'h7, d[2:0])
      `CHK("status high", m[1] ? 3'h0 : 3'h7, d[5:3])
      @(posedge ref_clk_i);
      evt <= 1'b0;
      wait_n(4);
      rd(OFS_STATUS, d);
      `CHK("event", 1'b0, d[STAT_EVT_LEVEL])
      `CHK("trip", m[1:0], d[9:8])
      wr(OFS_STATUS, 32'h0000_0300);
      rd(OFS_STATUS, d);
      `CHK("trip", 2'h0, d[9:8])
    end
    $display("test protect done");
  endtask
  initial begin
    rstn_i   = 1'b0;
    addr_i   = '0;
    wdata_i  = '0;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    ls_ctrl  = 3'h0;
    hs_ctrl  = 3'h0;
    evt      = 1'b0;
    failures = 0;
    checked  = 0;
    cycles   = 0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_idle();
    t_delay();
    t_protect();
    end_of_test();
  end
endmodule
